/* File: rtl/vip_pkg.sv */
// Overview of operation
// - Priority bit one lifts pin to level one
// - Group zero bits 0-2: MAC vectors 40-48
// - Group zero bits 3-4: PLL, flash vectors
// - Group zero bits 5-7: timers 0-2 vectors
// - Group one bit 0: timer 3 at 060h
// - Vectors 064h and 068h never issued
package vip_pkg;
  localparam int NUM_SRC = 21;                  // Source count
  localparam int VEC_W   = 8;                   // Vector width
  localparam int IDX_W   = 5;                   // Source index width
  // Source index to vector; gap at 064h/068h keeps NMI vector free
  localparam logic [VEC_W-1:0] VEC_BASE0 = 8'h40; // Indices 0..8
  localparam logic [VEC_W-1:0] VEC_BASE1 = 8'hA0; // Indices 9..20
  localparam int BASE1_IDX = 9;                 // First port B index
  localparam logic [VEC_W-1:0] VEC_NONE  = 8'h00; // Idle vector
  // APB register byte offsets
  localparam logic [7:0] OFS_GRP0   = 8'h00;    // Priority group zero
  localparam logic [7:0] OFS_GRP1   = 8'h04;    // Priority group one
  localparam logic [7:0] OFS_GRP3   = 8'h0C;    // Priority group three
  localparam logic [7:0] OFS_GRP4   = 8'h10;    // Priority group four
  localparam logic [7:0] OFS_STAT   = 8'h20;    // Sticky status (RO)
  localparam logic [7:0] OFS_CLR    = 8'h24;    // Status clear (WO)
  localparam logic [7:0] OFS_EN     = 8'h28;    // Enable
  localparam logic [7:0] OFS_VEC    = 8'h2C;    // Current vector (RO)
  localparam logic [31:0] RST_ZERO  = 32'h00000000; // Reset value
endpackage

/* File: rtl/vip_arbiter.sv */
`timescale 1ns/1ns
// Picks the winning source: level one first, then lowest index
module vip_arbiter import vip_pkg::*; #(
  parameter int N = NUM_SRC                     // Source count
) (
  input  wire logic [N-1:0]     pend,           // Pending sources
  input  wire logic [N-1:0]     lvl1,           // Level-one flags
  output logic                  hit,            // Any pending
  output logic [IDX_W-1:0]      idx             // Winner index
);
  logic [N-1:0] hiSet;                          // Pending at level one
  logic [N-1:0] pick;                           // Set actually searched

  // Search level one only if any exists
  always_comb begin
    hiSet = pend & lvl1;
    pick  = (|hiSet) ? hiSet : pend;
    hit   = |pend;
    idx   = '0;
    // Descending loop so lowest index wins last
    for (int i = N - 1; i >= 0; i--) begin
      if (pick[i]) begin
        idx = IDX_W'(i);
      end
    end
  end
endmodule

/* File: rtl/vip_top.sv */
`timescale 1ns/1ns
module vip_top import vip_pkg::*; (
  input  wire logic                 clk,        // 25 MHz clock
  input  wire logic                 rst,        // Async reset, high
  input  wire logic                 psel,       // APB select
  input  wire logic                 penable,    // APB access phase
  input  wire logic                 pwrite,     // APB write
  input  wire logic [7:0]           paddr,      // APB byte address
  input  wire logic [31:0]          pwdata,     // APB write data
  output logic                      pready,     // APB ready
  output logic [31:0]               prdata,     // APB read data
  output logic                      pslverr,    // APB error
  input  wire logic [NUM_SRC-1:0]   srcEvent,   // Source event pulses
  output logic                      irq,        // Interrupt level
  output logic [VEC_W-1:0]          vector      // Vector to core
);
  logic [7:0]         grp0_q;                   // Group zero bits
  logic               grp1_q;                   // Group one bit 0
  logic [7:0]         grp3_q;                   // Group three bits
  logic [1:0]         grp4_q;                   // Group four bits
  logic [NUM_SRC-1:0] stat_q;                   // Sticky status
  logic [NUM_SRC-1:0] en_q;                     // Enables
  logic [VEC_W-1:0]   vec_q;                    // Registered vector
  logic [NUM_SRC-1:0] lvl1;                     // Per-source level
  logic [NUM_SRC-1:0] clrMask;                  // Write-one clears
  logic               wrEn;                     // Write strobe
  logic               hit;                      // Arbiter any
  logic [IDX_W-1:0]   win;                      // Arbiter winner
  logic               mapped;                   // Address decodes

  // Index to vector; skips 064h/068h by rebasing port B
  function automatic logic [VEC_W-1:0] idx2vec(input logic [IDX_W-1:0] i);
    logic [VEC_W-1:0] w;
    w = VEC_W'(i);
    if (int'(i) < BASE1_IDX) begin
      idx2vec = VEC_BASE0 + (w << 2);
    end else begin
      idx2vec = VEC_BASE1 + ((w - VEC_W'(BASE1_IDX)) << 2);
    end
  endfunction

  // Source order: MAC rx,tx,sys, PLL, flash, T0-T2, T3, PB0-7, PC0-1
  // Sources 19 and 20 have no group bit and stay at default level
  assign lvl1 = NUM_SRC'({grp4_q, grp3_q, grp1_q, grp0_q});

  // APB decode; no wait states, so pready is simply tied high
  assign pready  = 1'b1;                        // Zero wait states
  assign wrEn    = psel & penable & pwrite;
  assign mapped  = paddr == OFS_GRP0 || paddr == OFS_GRP1 ||
                   paddr == OFS_GRP3 || paddr == OFS_GRP4 ||
                   paddr == OFS_STAT || paddr == OFS_CLR  ||
                   paddr == OFS_EN   || paddr == OFS_VEC;
  assign pslverr = psel & penable & ~mapped;
  assign clrMask = (wrEn && paddr == OFS_CLR) ? pwdata[NUM_SRC-1:0] : '0;

  // Priority registers, written in the access phase
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      grp0_q <= RST_ZERO[7:0];
      grp1_q <= RST_ZERO[0];
      grp3_q <= RST_ZERO[7:0];
      grp4_q <= RST_ZERO[1:0];
    end else if (wrEn) begin
      if (paddr == OFS_GRP0) grp0_q <= pwdata[7:0];
      if (paddr == OFS_GRP1) grp1_q <= pwdata[0];
      if (paddr == OFS_GRP3) grp3_q <= pwdata[7:0];
      if (paddr == OFS_GRP4) grp4_q <= pwdata[1:0];
    end
  end

  // Enable register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      en_q <= RST_ZERO[NUM_SRC-1:0];
    end else if (wrEn && paddr == OFS_EN) begin
      en_q <= pwdata[NUM_SRC-1:0];
    end
  end

  // Sticky status; a new event beats a clear in the same cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stat_q <= RST_ZERO[NUM_SRC-1:0];
    end else begin
      stat_q <= (stat_q & ~clrMask) | srcEvent;
    end
  end

  vip_arbiter #(
    .N    (NUM_SRC)
  ) u_arb (
    .pend (stat_q & en_q),
    .lvl1 (lvl1),
    .hit  (hit),
    .idx  (win)
  );

  // Vector register, one cycle behind status
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      vec_q <= VEC_NONE;
    end else begin
      vec_q <= hit ? idx2vec(win) : VEC_NONE;
    end
  end

  // irq is decoded from registered stat_q, so a clear drops it one cycle later, a cycle ahead of vector
  assign vector = vec_q;
  assign irq    = |(stat_q & en_q);

  // Read mux; unmapped and write-only read zero
  always_comb begin
    prdata = '0;
    case (paddr)
      OFS_GRP0: prdata[7:0] = grp0_q;
      OFS_GRP1: prdata[0]   = grp1_q;
      OFS_GRP3: prdata[7:0] = grp3_q;
      OFS_GRP4: prdata[1:0] = grp4_q;
      OFS_STAT: prdata[NUM_SRC-1:0] = stat_q;
      OFS_EN:   prdata[NUM_SRC-1:0] = en_q;
      OFS_VEC:  prdata[VEC_W-1:0]   = vec_q;
      default:  prdata = '0;
    endcase
  end

  // Reserved vectors stay clear of the NMI slot
  a_vec_gap: assert property (@(posedge clk) disable iff (rst)
    vector != 8'h64 && vector != 8'h68)
    else $error("Reserved vector issued");
  // Nothing enabled and pending gives the idle vector next cycle
  a_vec_idle: assert property (@(posedge clk) disable iff (rst)
    !irq |=> vector == VEC_NONE)
    else $error("Idle vector wrong");
  // An event always lands in status, even against a clear
  a_event_sets: assert property (@(posedge clk) disable iff (rst)
    srcEvent != '0 |=> (stat_q & $past(srcEvent)) == $past(srcEvent))
    else $error("Event lost in status");
  // An enabled event raises the level one cycle later
  a_irq_lvl: assert property (@(posedge clk) disable iff (rst)
    (|(srcEvent & en_q) && !(wrEn && paddr == OFS_EN)) |=> irq)
    else $error("Interrupt level wrong");
  // Two defaults pending: the lower vector goes first
  a_low_first: assert property (@(posedge clk) disable iff (rst)
    ((stat_q & en_q) == 21'h3 && lvl1[1:0] == 2'b00) |=> vector == 8'h40)
    else $error("Lower vector not first");
  // A lone source, a lone level-one source, or level-one MAC rx gets its fixed vector
  a_mac_rx: assert property (@(posedge clk) disable iff (rst)
    (stat_q[0] && en_q[0] && grp0_q[0]) |=> vector == 8'h40)
    else $error("MAC rx level one not first");
  a_mac_tx: assert property (@(posedge clk) disable iff (rst)
    ((stat_q & en_q & lvl1) == 21'h2) |=> vector == 8'h44)
    else $error("MAC tx vector wrong");
  a_mac_sys: assert property (@(posedge clk) disable iff (rst)
    ((stat_q & en_q & lvl1) == 21'h4) |=> vector == 8'h48)
    else $error("MAC sys vector wrong");
  a_pll_vec: assert property (@(posedge clk) disable iff (rst)
    ((stat_q & en_q) == 21'h8) |=> vector == 8'h4C)
    else $error("PLL vector wrong");
  a_pll_lvl: assert property (@(posedge clk) disable iff (rst)
    ((stat_q & en_q & lvl1) == 21'h8) |=> vector == 8'h4C)
    else $error("PLL level one vector wrong");
  a_flash_vec: assert property (@(posedge clk) disable iff (rst)
    ((stat_q & en_q & lvl1) == 21'h10) |=> vector == 8'h50)
    else $error("Flash vector wrong");
  a_t0_vec: assert property (@(posedge clk) disable iff (rst)
    ((stat_q & en_q & lvl1) == 21'h20) |=> vector == 8'h54)
    else $error("Timer 0 vector wrong");
  a_t1_vec: assert property (@(posedge clk) disable iff (rst)
    ((stat_q & en_q & lvl1) == 21'h40) |=> vector == 8'h58)
    else $error("Timer 1 vector wrong");
  a_t2_vec: assert property (@(posedge clk) disable iff (rst)
    ((stat_q & en_q & lvl1) == 21'h80) |=> vector == 8'h5C)
    else $error("Timer 2 vector wrong");
  a_t3_vec: assert property (@(posedge clk) disable iff (rst)
    ((stat_q & en_q & lvl1) == 21'h100) |=> vector == 8'h60)
    else $error("Timer 3 vector wrong");
  // Port pins sit above the gap, one word apart
  a_pb0_vec: assert property (@(posedge clk) disable iff (rst)
    ((stat_q & en_q & lvl1) == 21'h200) |=> vector == 8'hA0)
    else $error("Port B 0 vector wrong");
  a_pb1_vec: assert property (@(posedge clk) disable iff (rst)
    ((stat_q & en_q & lvl1) == 21'h400) |=> vector == 8'hA4)
    else $error("Port B 1 vector wrong");
  a_pb2_vec: assert property (@(posedge clk) disable iff (rst)
    ((stat_q & en_q & lvl1) == 21'h800) |=> vector == 8'hA8)
    else $error("Port B 2 vector wrong");
  a_pb3_vec: assert property (@(posedge clk) disable iff (rst)
    ((stat_q & en_q & lvl1) == 21'h1000) |=> vector == 8'hAC)
    else $error("Port B 3 vector wrong");
  a_pb4_vec: assert property (@(posedge clk) disable iff (rst)
    ((stat_q & en_q & lvl1) == 21'h2000) |=> vector == 8'hB0)
    else $error("Port B 4 vector wrong");
  a_pb5_vec: assert property (@(posedge clk) disable iff (rst)
    ((stat_q & en_q & lvl1) == 21'h4000) |=> vector == 8'hB4)
    else $error("Port B 5 vector wrong");
  a_pb6_vec: assert property (@(posedge clk) disable iff (rst)
    ((stat_q & en_q & lvl1) == 21'h8000) |=> vector == 8'hB8)
    else $error("Port B 6 vector wrong");
  a_pb7_vec: assert property (@(posedge clk) disable iff (rst)
    ((stat_q & en_q & lvl1) == 21'h10000) |=> vector == 8'hBC)
    else $error("Port B 7 vector wrong");
  a_pc0_vec: assert property (@(posedge clk) disable iff (rst)
    ((stat_q & en_q & lvl1) == 21'h20000) |=> vector == 8'hC0)
    else $error("Port C 0 vector wrong");
  a_pc1_vec: assert property (@(posedge clk) disable iff (rst)
    ((stat_q & en_q & lvl1) == 21'h40000) |=> vector == 8'hC4)
    else $error("Port C 1 vector wrong");
  // Level-one port C pin beats a pending default MAC event
  a_lvl_first: assert property (@(posedge clk) disable iff (rst)
    (stat_q[0] && en_q[0] && !lvl1[0]
     && (stat_q & en_q & lvl1) == 21'h40000) |=> vector == 8'hC4)
    else $error("Level one source not first");
  // Main scenarios worth seeing
  c_two_lvl: cover property (@(posedge clk) disable iff (rst)
    hit && |(stat_q & en_q & lvl1) && |(stat_q & en_q & ~lvl1));
  c_clr_set: cover property (@(posedge clk) disable iff (rst)
    |(clrMask & srcEvent));
  c_pb_vec: cover property (@(posedge clk) disable iff (rst)
    vector == 8'hA0);
  c_t3_vec: cover property (@(posedge clk) disable iff (rst)
    vector == 8'h60);
  c_pc_lvl: cover property (@(posedge clk) disable iff (rst)
    vector == 8'hC4);
endmodule

/* File: test/vip_core_model.sv */
`timescale 1ns/1ns
// Core stand-in: fetches the offered vector while irq is high
module vip_core_model import vip_pkg::*; (
  input  wire logic             clk,     // System clock
  input  wire logic             rst,     // Async reset, high
  input  wire logic             irq,     // Interrupt level
  input  wire logic [VEC_W-1:0] vector,  // Offered vector
  output logic      [VEC_W-1:0] takenVec // Last vector fetched
);
  // A lagging fetch exposes a vector that settles late
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      takenVec <= VEC_NONE;
    end else if (irq) begin
      takenVec <= vector;
    end
  end
endmodule

/* File: test/vip_top_tb.sv */
`timescale 1ns/1ns
module vip_top_tb import vip_pkg::*;;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, irq;
  logic [7:0] paddr, vector, taken;         // Address and vectors
  logic [31:0] pwdata, prdata, rd;          // Bus data
  logic [NUM_SRC-1:0] srcEvent;             // Event pulses
  logic errSeen;                            // pslverr at the answer edge
  int miscompares, samples_checked, ofs, b; // Counters, group slot
  vip_top dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .srcEvent(srcEvent),
    .irq(irq), .vector(vector));
  vip_core_model core (.clk(clk), .rst(rst), .irq(irq),
    .vector(vector), .takenVec(taken));
  // Free-running 25 MHz clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // Verdict: the only place the run ends
  task automatic results();
    if (miscompares == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask
  // APB transfer; one idle edge first so psel never toggles twice at once
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
    int n;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    // Answer is taken at the edge where pready is seen high
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 40);
    if (n >= 40) begin
      miscompares++;
      results();
    end
    rd      = prdata;
    errSeen = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic pulse(logic [NUM_SRC-1:0] m);
    @(posedge clk);
    srcEvent <= m;
    @(posedge clk);
    srcEvent <= '0;
    repeat (3) @(posedge clk);
  endtask
  // Masked event stays silent until enabled, then clears
  task automatic mask_scn();
    pulse(21'h8);
    chk("irq_masked", 0, irq);
    apb(1'b0, OFS_STAT, 0);
    chk("stat", 32'h8, rd);
    apb(1'b0, 8'h30, 0);
    chk("unmapped", 1, errSeen);
    chk("unmapped_rd", 0, rd);
    apb(1'b1, OFS_EN, 32'h1FFFFF);
    @(posedge clk);
    chk("irq_on", 1, irq);
    apb(1'b0, OFS_VEC, 0);
    chk("vec_reg", 8'h4C, rd);
    apb(1'b1, OFS_CLR, 32'h8);
    @(posedge clk);
    chk("irq_clr", 0, irq);
  endtask
  // Source 0 against source k: lowest vector, then level one wins
  task automatic prio_scn(int k);
    logic [7:0] ev;
    ev = (k < 9) ? 8'h40 + 8'(4 * k) : 8'hA0 + 8'(4 * (k - 9));
    ofs = k < 8 ? OFS_GRP0 : k == 8 ? OFS_GRP1 : k < 17 ? OFS_GRP3 : OFS_GRP4;
    b = k < 8 ? k : k == 8 ? 0 : k < 17 ? k - 9 : k - 17;
    pulse(21'h1 | (21'h1 << k));
    chk("vec_default", 8'h40, taken);
    apb(1'b1, 8'(ofs), 32'h1 << b);
    repeat (3) @(posedge clk);
    if (k < 9) begin
      chk("vec_level1", ev, taken);
    end else begin
      chk("vec_pin_lvl1", ev, taken);
    end
    apb(1'b1, 8'(ofs), 0);
    apb(1'b1, OFS_CLR, 32'h1FFFFF);
  endtask
  initial begin
    rst             = 1'b1;
    psel            = 1'b0;
    penable         = 1'b0;
    pwrite          = 1'b0;
    paddr           = '0;
    pwdata          = '0;
    srcEvent        = '0;
    errSeen         = 1'b0;
    miscompares     = 0;
    samples_checked = 0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    chk("vec_rst", VEC_NONE, vector);
    apb(1'b0, OFS_GRP0, 0);
    chk("grp0_rst", RST_ZERO, rd);
    mask_scn();
    for (int k = 1; k < 19; k++) begin
      prio_scn(k);
    end
    results();
  end
endmodule
